// ===== src/optical_module_ctrl_status.sv
// control, status and management logic of the optical transceiver module
//
// Contract
// - The transmitter is off while the shutdown input is high and on while it is low.
// - An open shutdown input reads high through the pad pull-up, so the laser stays off.
// - A high-then-low cycle of the shutdown input clears the fault state and restores output.
// - A catastrophic laser fault turns the laser off and raises the fault output.
// - The fault output stays latched until the shutdown input is toggled or power is cycled.
// - The fault state reads as bit 2 of status byte 110 at the diagnostic address.
// - An eye-safety monitor on output power turns the transmitter off and raises the fault.
// - The loss-of-signal output is low with usable input power and high when it is unusable.
// - The loss-of-signal state reads as bit 1 of status byte 110 at the diagnostic address.
// - Reads at address 0xA0 return a 256-byte identification memory, offsets 0 to 255.
// - Address 0xB0 is reserved for internal test use and is not answered for the host.
// - Address 0xA2 holds a 256-byte diagnostic memory with five live monitor values.
// - Monitor values are calibrated inside the module before they are reported.
`timescale 1ns/100ps
`default_nettype none
`include "optical_module_params.svh"

module optical_module_ctrl_status #(
    parameter logic [15:0] VENDOR_CODE = 16'h5a5a, // arbitrary value
    parameter logic [15:0] EYE_SAFE_LIMIT = `EYE_SAFE_LIMIT,
    parameter logic [4:0][15:0] CAL_SLOPE = {5{`CAL_SLOPE_UNITY}},
    parameter logic [4:0][15:0] CAL_OFFSET = {5{`CAL_OFFSET_ZERO}}
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic tx_disable,
    input wire logic laser_fault_detect,
    input wire logic signal_detect,
    input wire optical_module_pkg::mon_array_t mon_raw,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic laser_enable,
    output logic tx_fault,
    output logic tx_fault_out,
    output logic tx_fault_oe_n,
    output logic receive_input_lost,
    output logic receive_input_lost_out,
    output logic receive_input_lost_oe_n
);
    import optical_module_pkg::*;

    logic tx_disable_q_reg;
    logic fault_reg;
    logic fault_set;
    logic fault_clear;
    logic eye_unsafe_reg;
    logic laser_enable_reg;
    logic optical_input_lost_reg;
    mon_array_t cal_reg;
    mem_req_t mem_req;
    logic [7:0] rd_byte;
    logic [7:0] status_byte;
    logic [7:0] id_byte;
    logic [7:0] diag_byte;
    logic [7:0] mon_index;

    // per-channel calibration: 8.8 slope then offset, one cycle of latency
    genvar ch;
    generate
        for (ch = 0; ch < MON_CHANNELS; ch++) begin : g_cal
            logic [31:0] product;
            assign product = 32'(mon_raw[ch]) * 32'(CAL_SLOPE[ch]);
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    cal_reg[ch] <= 16'h0000;
                end else begin
                    cal_reg[ch] <= product[23:8] + CAL_OFFSET[ch];
                end
            end
        end
    endgenerate

    // eye safety looks at the calibrated transmit power every cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            eye_unsafe_reg <= 1'b0;
        end else begin
            eye_unsafe_reg <= (cal_reg[MON_TX_POWER] > EYE_SAFE_LIMIT);
        end
    end

    // reset value high: treats the shutdown pin as asserted until sampled
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_disable_q_reg <= 1'b1;
        end else begin
            tx_disable_q_reg <= tx_disable;
        end
    end

    assign fault_set = laser_fault_detect | eye_unsafe_reg;
    // only the falling edge ends a toggle, so an assert-then-deassert clears
    assign fault_clear = tx_disable_q_reg & ~tx_disable;

    // a new fault in the clearing cycle wins, so no fault is lost
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_reg <= 1'b0;
        end else if (fault_set) begin
            fault_reg <= 1'b1;
        end else if (fault_clear) begin
            fault_reg <= 1'b0;
        end
    end

    // laser held off through reset; pad pull-up makes an open pin read high
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            laser_enable_reg <= 1'b0;
        end else begin
            laser_enable_reg <= ~tx_disable & ~fault_reg & ~fault_set;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            optical_input_lost_reg <= 1'b1;
        end else begin
            optical_input_lost_reg <= ~signal_detect;
        end
    end

    assign laser_enable = laser_enable_reg;
    assign tx_fault = fault_reg;
    assign receive_input_lost = optical_input_lost_reg;
    // open-collector pins: pull low when the line should read low
    assign tx_fault_out = 1'b0;
    assign tx_fault_oe_n = fault_reg;
    assign receive_input_lost_out = 1'b0;
    assign receive_input_lost_oe_n = optical_input_lost_reg;

    // built from the live flops each time the target fetches the byte
    always_comb begin
        status_byte = `DIAG_STATUS_RESET;
        status_byte[`STATUS_FAULT_BIT] = fault_reg;
        status_byte[`STATUS_LOST_BIT] = optical_input_lost_reg;
    end

    // identification memory is constant; unlisted offsets read zero
    always_comb begin
        unique case (mem_req.addr)
            `ID_BYTE0_OFFSET: id_byte = `ID_BYTE0_VALUE;
            `ID_BYTE1_OFFSET: id_byte = `ID_BYTE1_VALUE;
            `ID_VENDOR_OFFSET: id_byte = VENDOR_CODE[15:8];
            `ID_VENDOR_OFFSET + 8'h01: id_byte = VENDOR_CODE[7:0];
            default: id_byte = 8'h00;
        endcase
    end

    // monitors sit as big-endian words from the monitor base upward
    always_comb begin
        mon_index = mem_req.addr - `DIAG_MON_BASE;
        diag_byte = 8'h00;
        if (mem_req.addr == `DIAG_STATUS_OFFSET) begin
            diag_byte = status_byte;
        end else if (mem_req.addr >= `DIAG_MON_BASE &&
                     mon_index < 8'(2 * MON_CHANNELS)) begin
            diag_byte = mon_index[0] ? cal_reg[mon_index[3:1]][7:0]
                                     : cal_reg[mon_index[3:1]][15:8];
        end
    end

    assign rd_byte = mem_req.page ? diag_byte : id_byte;

    two_wire_target u_target (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .mem_req(mem_req),
        .rd_byte(rd_byte)
    );
endmodule // optical_module_ctrl_status

`default_nettype wire

// ===== src/optical_module_params.svh
// constants of the optical module control and management block
`ifndef OPTICAL_MODULE_PARAMS_SVH
`define OPTICAL_MODULE_PARAMS_SVH

// two-wire device addresses, 8-bit form with the read/write bit clear
`define DEV_ADDR_ID 8'ha0
`define DEV_ADDR_DIAG 8'ha2
`define DEV_ADDR_TEST 8'hb0

// diagnostic memory layout
`define DIAG_STATUS_OFFSET 8'h6e
`define STATUS_FAULT_BIT 2
`define STATUS_LOST_BIT 1
`define DIAG_MON_BASE 8'h60
`define DIAG_STATUS_RESET 8'h00

// identification memory contents
`define ID_BYTE0_OFFSET 8'h00
`define ID_BYTE0_VALUE 8'h80
`define ID_BYTE1_OFFSET 8'h01
`define ID_BYTE1_VALUE 8'h04
`define ID_VENDOR_OFFSET 8'h25

// host spacing between transmit-shutdown assertions
`define TX_DIS_SPACING_MS 10
`define CLK_KHZ 50000

// calibration defaults: unity slope in 8.8 fixed point, zero offset
`define CAL_SLOPE_UNITY 16'h0100
`define CAL_OFFSET_ZERO 16'h0000
`define EYE_SAFE_LIMIT 16'hf000

`endif

// ===== src/optical_module_pkg.sv
// types of the optical module control and management block
package optical_module_pkg;
    localparam int MON_CHANNELS = 5;
    typedef logic [15:0] mon_word_t;
    typedef mon_word_t [MON_CHANNELS-1:0] mon_array_t;
    typedef enum logic [2:0] {
        MON_TEMP,
        MON_VCC,
        MON_BIAS,
        MON_TX_POWER,
        MON_RX_POWER
    } mon_chan_t;
    typedef enum {
        ST_IDLE, ST_DEV, ST_ACK_DEV, ST_WADDR, ST_ACK_WADDR,
        ST_WDATA, ST_ACK_WDATA, ST_RDATA, ST_RACK
    } tw_state_t;
    typedef struct packed {
        logic page;
        logic [7:0] addr;
    } mem_req_t;
endpackage

// ===== src/two_wire_target.sv
// two-wire serial memory target answering at the identity and diagnostic addresses
`timescale 1ns/100ps
`default_nettype none
`include "optical_module_params.svh"

module two_wire_target (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output var optical_module_pkg::mem_req_t mem_req,
    input wire logic [7:0] rd_byte
);
    import optical_module_pkg::*;

    tw_state_t state_reg;
    logic scl_q_reg;
    logic sda_q_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] ptr_reg;
    logic page_reg;
    logic read_reg;
    logic drive_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic byte_full;

    assign scl_rise = scl_in & ~scl_q_reg;
    assign scl_fall = ~scl_in & scl_q_reg;
    assign start_seen = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    assign stop_seen = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
    assign byte_full = (bit_cnt_reg == 4'h8);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
        end
    end

    // the target only ever pulls low, so the data output level is fixed
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            ptr_reg <= 8'h00;
            page_reg <= 1'b0;
            read_reg <= 1'b0;
            drive_reg <= 1'b0;
        end else if (start_seen) begin
            // repeated start keeps the pointer, giving random reads
            state_reg <= ST_DEV;
            bit_cnt_reg <= 4'h0;
            drive_reg <= 1'b0;
        end else if (stop_seen) begin
            state_reg <= ST_IDLE;
            drive_reg <= 1'b0;
        end else if (scl_rise) begin
            unique case (state_reg)
                ST_DEV, ST_WADDR, ST_WDATA: begin
                    shift_reg <= {shift_reg[6:0], sda_in};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                ST_RACK: begin
                    if (sda_in) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (state_reg)
                ST_DEV: begin
                    if (byte_full) begin
                        // the test address and all others get no acknowledge
                        if (shift_reg[7:1] == `DEV_ADDR_ID >> 1 ||
                            shift_reg[7:1] == `DEV_ADDR_DIAG >> 1) begin
                            drive_reg <= 1'b1;
                            page_reg <= shift_reg[1];
                            read_reg <= shift_reg[0];
                            state_reg <= ST_ACK_DEV;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_DEV, ST_RACK: begin
                    if (read_reg) begin
                        shift_reg <= rd_byte;
                        drive_reg <= ~rd_byte[7];
                        bit_cnt_reg <= 4'h1;
                        state_reg <= ST_RDATA;
                    end else begin
                        drive_reg <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= ST_WADDR;
                    end
                end
                ST_WADDR: begin
                    if (byte_full) begin
                        ptr_reg <= shift_reg;
                        drive_reg <= 1'b1;
                        state_reg <= ST_ACK_WADDR;
                    end
                end
                ST_WDATA: begin
                    // memories are read-only: data is acknowledged and dropped
                    if (byte_full) begin
                        ptr_reg <= ptr_reg + 8'h01;
                        drive_reg <= 1'b1;
                        state_reg <= ST_ACK_WDATA;
                    end
                end
                ST_ACK_WADDR, ST_ACK_WDATA: begin
                    drive_reg <= 1'b0;
                    bit_cnt_reg <= 4'h0;
                    state_reg <= ST_WDATA;
                end
                ST_RDATA: begin
                    if (byte_full) begin
                        drive_reg <= 1'b0;
                        ptr_reg <= ptr_reg + 8'h01;
                        state_reg <= ST_RACK;
                    end else begin
                        drive_reg <= ~shift_reg[6];
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                ST_IDLE: begin
                end
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = ~drive_reg;
    // one driver for the whole request word
    assign mem_req = '{page: page_reg, addr: ptr_reg};
endmodule // two_wire_target

`default_nettype wire

// ===== test/host_board_model.sv
// host board model: two-wire bus master with a pull-up on the data line
`timescale 1ns/100ps
`default_nettype none
module host_board_model (
    input wire logic sys_clk,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    output logic scl,
    output logic sda_line
);
    logic sda_drv_n;
    logic got_nack;
    logic [7:0] rd_buf [0:15];
    // wired-and with the pull-up: a released line reads high
    assign sda_line = sda_drv_n & (sda_oe_n | sda_out);
    initial begin
        scl <= 1'b1;
        sda_drv_n <= 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // data moves only with the clock low; sampled mid-high, away from target updates
    task automatic bit_io(input logic b, output logic r);
        sda_drv_n <= b;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(4);
        r = sda_line;
        wait_clk(4);
        scl <= 1'b0;
        wait_clk(4);
    endtask
    task automatic start_cond();
        sda_drv_n <= 1'b1;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(4);
        sda_drv_n <= 1'b0;
        wait_clk(4);
        scl <= 1'b0;
        wait_clk(4);
    endtask
    task automatic stop_cond();
        sda_drv_n <= 1'b0;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(4);
        sda_drv_n <= 1'b1;
        wait_clk(4);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] r,
                           output logic ack_seen);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(ack, ack_seen);
    endtask
    // random read; the last byte gets a nack so the target lets go of the line
    task automatic mem_read(input logic [7:0] dev, input logic [7:0] off, input int n);
        logic [7:0] r;
        logic a;
        start_cond();
        byte_io(dev, 1'b1, r, got_nack);
        if (!got_nack) begin
            byte_io(off, 1'b1, r, a);
            start_cond();
            byte_io(dev | 8'h01, 1'b1, r, a);
            for (int i = 0; i < n; i++) byte_io(8'hff, i == n - 1, rd_buf[i], a);
        end
        stop_cond();
    endtask
endmodule // host_board_model
`default_nettype wire

// ===== test/optical_module_ctrl_status_sva.sv
// assertion checker for the optical module control and status ports
`timescale 1ns/100ps
`default_nettype none
module optical_module_ctrl_status_sva (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic tx_disable,
    input wire logic laser_fault_detect,
    input wire logic signal_detect,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic laser_enable,
    input wire logic tx_fault,
    input wire logic tx_fault_out,
    input wire logic tx_fault_oe_n,
    input wire logic receive_input_lost,
    input wire logic receive_input_lost_out,
    input wire logic receive_input_lost_oe_n
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    chk_shutdown_laser_off: assert property (tx_disable |=> !laser_enable)
        else $error("laser on while shutdown high");
    chk_fault_sets: assert property (laser_fault_detect |=> tx_fault)
        else $error("fault input not latched");
    chk_fault_laser_off: assert property (tx_fault |=> !laser_enable)
        else $error("laser on with fault latched");
    chk_fault_holds: assert property (tx_fault && !$fell(tx_disable) |=> tx_fault)
        else $error("fault cleared without shutdown toggle");
    chk_fault_clears: assert property (
        tx_fault && $fell(tx_disable) && !laser_fault_detect |=> !tx_fault)
        else $error("shutdown toggle did not clear fault");
    chk_lost_follows: assert property (1'b1 |=> receive_input_lost == !$past(signal_detect))
        else $error("loss flag not following signal detect");
    chk_fault_pin: assert property (tx_fault_oe_n == tx_fault && !tx_fault_out)
        else $error("fault pin disagrees with fault flag");
    chk_lost_pin: assert property (
        receive_input_lost_oe_n == receive_input_lost && !receive_input_lost_out)
        else $error("loss pin disagrees with loss flag");
    chk_sda_pull_only: assert property (!sda_out)
        else $error("data line driven high");
    chk_sda_steady_high: assert property (scl_in [*3] |-> $stable(sda_oe_n))
        else $error("data line moved while clock high");

    cover property (tx_fault ##1 !tx_fault);
    cover property ($rose(receive_input_lost));
    cover property (!sda_oe_n);
endmodule // optical_module_ctrl_status_sva

bind optical_module_ctrl_status optical_module_ctrl_status_sva u_sva (
    .sys_clk(sys_clk), .arst_n(arst_n), .tx_disable(tx_disable),
    .laser_fault_detect(laser_fault_detect), .signal_detect(signal_detect),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .laser_enable(laser_enable), .tx_fault(tx_fault), .tx_fault_out(tx_fault_out),
    .tx_fault_oe_n(tx_fault_oe_n), .receive_input_lost(receive_input_lost),
    .receive_input_lost_out(receive_input_lost_out),
    .receive_input_lost_oe_n(receive_input_lost_oe_n)
);
`default_nettype wire

// ===== test/optical_module_ctrl_status_tb.sv
// self-checking testbench of the optical module control and status block
`timescale 1ns/100ps
`default_nettype none
`include "optical_module_params.svh"
module optical_module_ctrl_status_tb;
    import optical_module_pkg::*;
    logic sys_clk, arst_n, tx_disable, laser_fault_detect, signal_detect, scl, sda;
    logic sda_out, sda_oe_n, laser_enable, tx_fault, f_out, f_oe_n, lost, l_out, l_oe_n;
    mon_array_t mon_raw;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;

    optical_module_ctrl_status DUT (.sys_clk(sys_clk), .arst_n(arst_n),
        .tx_disable(tx_disable), .laser_fault_detect(laser_fault_detect),
        .signal_detect(signal_detect), .mon_raw(mon_raw), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .laser_enable(laser_enable),
        .tx_fault(tx_fault), .tx_fault_out(f_out), .tx_fault_oe_n(f_oe_n),
        .receive_input_lost(lost), .receive_input_lost_out(l_out),
        .receive_input_lost_oe_n(l_oe_n));
    host_board_model host (.sys_clk(sys_clk), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .scl(scl), .sda_line(sda));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // looked at mid-cycle so that edge updates have landed
    task automatic flags(input logic [2:0] exp);
        @(negedge sys_clk);
        check("laser fault lost", {5'h0, laser_enable, tx_fault, lost}, {5'h0, exp});
        check("fault and loss pins", {3'h0, sda_out, f_oe_n, f_out, l_oe_n, l_out},
              {4'h0, exp[1], 1'b0, exp[0], 1'b0});
        @(posedge sys_clk);
    endtask
    task automatic status(input logic f, input logic l);
        host.mem_read(`DEV_ADDR_DIAG, `DIAG_STATUS_OFFSET, 1);
        check("status", host.rd_buf[0], 8'(f) << `STATUS_FAULT_BIT | 8'(l) << `STATUS_LOST_BIT);
    endtask

    initial begin
        arst_n <= 1'b0;
        tx_disable <= 1'b0;
        laser_fault_detect <= 1'b0;
        signal_detect <= 1'b1;
        mon_raw <= '0;
        clk(20);
        flags(3'b001);
        arst_n <= 1'b1;
        clk(3);
        flags(3'b100);
        host.mem_read(`DEV_ADDR_ID, `ID_BYTE0_OFFSET, 2);
        check("id byte 0", host.rd_buf[0], `ID_BYTE0_VALUE);
        check("id byte 1", host.rd_buf[1], `ID_BYTE1_VALUE);
        // the reserved test address must leave the bus alone
        host.mem_read(`DEV_ADDR_TEST, 8'h00, 1);
        check("test address nack", 8'(host.got_nack), 8'h01);
        // channel i holds 16'h1234 plus i times 16'h0101, highest channel first
        mon_raw <= {16'h1638, 16'h1537, 16'h1436, 16'h1335, 16'h1234};
        clk(4);
        host.mem_read(`DEV_ADDR_DIAG, `DIAG_MON_BASE, 2 * MON_CHANNELS);
        for (int i = 0; i < MON_CHANNELS; i++) begin
            check("monitor msb", host.rd_buf[2 * i], 8'h12 + 8'(i));
            check("monitor lsb", host.rd_buf[2 * i + 1], 8'h34 + 8'(i));
        end
        signal_detect <= 1'b0;
        clk(2);
        flags(3'b101);
        status(1'b0, 1'b1);
        signal_detect <= 1'b1;
        clk(2);
        flags(3'b100);
        status(1'b0, 1'b0);
        laser_fault_detect <= 1'b1;
        clk(1);
        laser_fault_detect <= 1'b0;
        clk(3);
        flags(3'b010);
        status(1'b1, 1'b0);
        flags(3'b010);
        // the only shutdown assertion of the run, so the spacing rule holds trivially
        tx_disable <= 1'b1;
        clk(3);
        flags(3'b010);
        tx_disable <= 1'b0;
        clk(3);
        flags(3'b100);
        // unity calibration, so this raw value lands just above the safety limit
        mon_raw[3] <= 16'hf001;
        clk(6);
        flags(3'b010);
        status(1'b1, 1'b0);
        // a mid-run reset stands for a power cycle and must drop the latched fault
        arst_n <= 1'b0;
        mon_raw[3] <= 16'h0000;
        clk(2);
        flags(3'b001);
        arst_n <= 1'b1;
        clk(3);
        flags(3'b100);
        print_verdict();
    end
endmodule // optical_module_ctrl_status_tb
`default_nettype wire
